/* File: design/interrupt_priority_vectoring.sv */
// Interrupt priority and vectoring: picks one pending request, forms its fetch address.
// Assumes the core acknowledges each grant, and requests stay set until serviced.
//
// Contract
// - Higher level always served before lower level.
// - Same level: smallest vector number wins.
// - Fetch address is vector base plus offset.
// - Vectors 0 and 1 never issued.
// - Core exceptions vectors 2-5 at level 3.
// - Debug vectors 6,7,9,10,11 use levels 1-3.
// - Software 14,15,16 fixed; others levels 0-2.
// - Low voltage vector 20, clock vector 21.
// - Flash requests at vectors 22, 23, 24.
// - Bus controller 26-29; ports F-A 30-35.
// - Serial peripheral units at vectors 38 to 41.
// - Async serial port 1 at 42,43,45,46.
// - Quadrature decoders at vectors 47 to 50.
// - Each entry two words; offset twice vector.
`timescale 1ns/1ps
`include "ipv_defs.svh"

module interrupt_priority_vectoring
    import ipv_pkg::*;
#(
    parameter int NUM_VEC = `IPV_NUM_VEC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // On-chip requests, one per vector slot, same clock
    input wire logic [NUM_VEC-1:0] req,
    input wire logic [NUM_VEC-1:0][`IPV_LVL_W-1:0] level_cfg,
    // External request pins
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    // Core side
    input wire logic [`IPV_ADDR_W-1:0] vector_base_register,
    input wire logic irq_ack,
    output logic irq_valid,
    output grant_s grant
);

    if (NUM_VEC < `IPV_NUM_VEC || NUM_VEC > `IPV_MAX_VEC) begin : g_bad_num_vec
        $error("NUM_VEC out of the range the vector field serves");
    end

    function automatic vec_class_e vec_class(input int unsigned v);
        logic [`IPV_MAX_VEC-1:0] rsvd;
        vec_class_e c;
        rsvd = `IPV_RSVD_MASK;
        c = VC_PERIPH;
        if (v >= NUM_VEC || rsvd[v]) begin
            c = VC_RSVD;
        end else if (v >= `IPV_VEC_CORE_LO && v <= `IPV_VEC_CORE_HI) begin
            c = VC_CORE;
        end else if (v >= `IPV_VEC_DBG_LO && v <= `IPV_VEC_DBG_HI) begin
            c = VC_DEBUG;
        end else if (v == `IPV_VEC_SW2) begin
            c = VC_SW2;
        end else if (v == `IPV_VEC_SW1) begin
            c = VC_SW1;
        end else if (v == `IPV_VEC_SW0) begin
            c = VC_SW0;
        end
        return c;
    endfunction

    function automatic logic [`IPV_LVL_W-1:0] eff_level(input int unsigned v,
                                                       input logic [`IPV_LVL_W-1:0] cfg);
        logic [`IPV_LVL_W-1:0] l;
        l = `IPV_LVL_0;
        case (vec_class(v))
            VC_CORE: l = `IPV_LVL_3;
            VC_DEBUG: l = (cfg == `IPV_LVL_0) ? `IPV_LVL_1 : cfg;
            VC_SW2: l = `IPV_LVL_2;
            VC_SW1: l = `IPV_LVL_1;
            VC_SW0: l = `IPV_LVL_0;
            VC_PERIPH: l = (cfg == `IPV_LVL_3) ? `IPV_LVL_2 : cfg;
            default: l = `IPV_LVL_0;
        endcase
        return l;
    endfunction

    // External pins are asynchronous and pass two flip-flops first.
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] next_sync_a;
    logic [1:0] next_sync_b;

    always_comb begin
        next_sync_a = {sync_a[0], ext_request_a};
        next_sync_b = {sync_b[0], ext_request_b};
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync_a <= `IPV_SYNC_RST;
            sync_b <= `IPV_SYNC_RST;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    logic [NUM_VEC-1:0] pend;
    logic [`IPV_LVL_W-1:0] lvl [NUM_VEC];

    for (genvar g = 0; g < NUM_VEC; g++) begin : g_slot
        logic src;
        if (g == `IPV_VEC_EXT_A) begin : g_ext_a
            assign src = sync_a[1];
        end else if (g == `IPV_VEC_EXT_B) begin : g_ext_b
            assign src = sync_b[1];
        end else begin : g_onchip
            assign src = req[g];
        end
        assign pend[g] = src && (vec_class(g) != VC_RSVD);
        assign lvl[g] = eff_level(g, level_cfg[g]);
    end

    // Arbitration: scanning downward with >= lets the smaller vector win a tie.
    logic found;
    logic [`IPV_VEC_W-1:0] pick_vec;
    logic [`IPV_LVL_W-1:0] pick_lvl;

    always_comb begin
        found = 1'b0;
        pick_vec = `IPV_VEC_W'(0);
        pick_lvl = `IPV_LVL_0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (pend[i] && (!found || lvl[i] >= pick_lvl)) begin
                found = 1'b1;
                pick_vec = `IPV_VEC_W'(i);
                pick_lvl = lvl[i];
            end
        end
    end

    // Grant state: the winner is captured and held until the core acknowledges.
    arb_state_e state;
    arb_state_e next_state;
    grant_s next_grant;
    logic next_irq_valid;

    always_comb begin
        next_state = state;
        next_grant = grant;
        next_irq_valid = irq_valid;
        case (state)
            ST_IDLE: begin
                if (found) begin
                    next_state = ST_GRANT;
                    next_irq_valid = 1'b1;
                    next_grant.vector = pick_vec;
                    next_grant.level = pick_lvl;
                    next_grant.addr = vector_base_register +
                                      `IPV_ADDR_W'({pick_vec, 1'b0});
                end
            end
            ST_GRANT: begin
                if (irq_ack) begin
                    next_state = ST_IDLE;
                    next_irq_valid = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_irq_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            irq_valid <= 1'b0;
            grant <= `IPV_GRANT_RST;
        end else begin
            state <= next_state;
            irq_valid <= next_irq_valid;
            grant <= next_grant;
        end
    end

    // Helper logic read only by the checks below.
    logic [`IPV_LVL_W-1:0] max_lvl;
    logic tie_lower;

    always_comb begin
        max_lvl = `IPV_LVL_0;
        tie_lower = 1'b0;
        for (int i = 0; i < NUM_VEC; i++) begin
            if (pend[i] && lvl[i] > max_lvl) begin
                max_lvl = lvl[i];
            end
            if (pend[i] && lvl[i] == pick_lvl && `IPV_VEC_W'(i) < pick_vec) begin
                tie_lower = 1'b1;
            end
        end
    end

    a_level_order: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (state == ST_IDLE && found) |=> irq_valid && grant.level == $past(max_lvl))
        else $error("Granted level is below the highest pending level");

    a_lowest_vector: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (state == ST_IDLE && found) |-> !tie_lower)
        else $error("A smaller vector at the same level was passed over");

    a_fetch_address: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $rose(irq_valid) |-> grant.addr ==
            $past(vector_base_register) + `IPV_ADDR_W'({grant.vector, 1'b0}))
        else $error("Fetch address is not base plus twice the vector");

    a_no_reserved: assert property (
        @(posedge mclk) disable iff (!rst_b)
        irq_valid |-> vec_class(grant.vector) != VC_RSVD && grant.vector > 6'h01)
        else $error("A reserved vector slot was granted");

    a_core_level: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (irq_valid && vec_class(grant.vector) == VC_CORE) |-> grant.level == `IPV_LVL_3)
        else $error("Core exception granted below level 3");

    a_debug_level: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (irq_valid && vec_class(grant.vector) == VC_DEBUG) |-> grant.level != `IPV_LVL_0)
        else $error("Debug request granted at level 0");

    a_periph_level: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (irq_valid && vec_class(grant.vector) == VC_PERIPH) |-> grant.level != `IPV_LVL_3)
        else $error("Assignable request granted at level 3");

    a_grant_held: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (irq_valid && !irq_ack) |=> irq_valid && $stable(grant))
        else $error("Grant changed before the acknowledge");

    a_ack_release: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (irq_valid && irq_ack) |=> !irq_valid ##1 (irq_valid == $past(found)))
        else $error("Grant did not drop after acknowledge or did not re-arbitrate");

    a_ext_latency: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (ext_request_a && state == ST_IDLE) [*3] |-> found)
        else $error("External request A not pending after two sync stages");

endmodule

/* File: design/ipv_defs.svh */
// Constants of the interrupt priority and vectoring block.
// Assumes inclusion by its bare name from the package and the design module.
`ifndef IPV_DEFS_SVH
`define IPV_DEFS_SVH

// Field widths of a grant.
`define IPV_VEC_W 6
`define IPV_LVL_W 2
`define IPV_ADDR_W 21

// Number of vector slots served by default, and the largest the vector field holds.
`define IPV_NUM_VEC 51
`define IPV_MAX_VEC 64

// Vector slots that are never issued: reset overlays 0 and 1, then the gaps.
`define IPV_RSVD_MASK 64'h0000_1030_0208_3103

// Vector slots with a fixed or restricted level, and the two slots fed by the external pins.
`define IPV_VEC_CORE_LO 6'h02
`define IPV_VEC_CORE_HI 6'h05
`define IPV_VEC_DBG_LO 6'h06
`define IPV_VEC_DBG_HI 6'h0b
`define IPV_VEC_SW2 6'h0e
`define IPV_VEC_SW1 6'h0f
`define IPV_VEC_SW0 6'h10
`define IPV_VEC_EXT_A 6'h11
`define IPV_VEC_EXT_B 6'h12

// Priority levels.
`define IPV_LVL_3 2'h3
`define IPV_LVL_2 2'h2
`define IPV_LVL_1 2'h1
`define IPV_LVL_0 2'h0

// Reset values.
`define IPV_GRANT_RST 29'h0000_0000
`define IPV_SYNC_RST 2'h0

`endif

/* File: design/ipv_pkg.sv */
// Types of the interrupt priority and vectoring block.
// Assumes ipv_defs.svh is on the include path.
`include "ipv_defs.svh"

package ipv_pkg;

    // Vector slot classes, which decide how a slot's level is formed.
    typedef enum logic [2:0] {
        VC_RSVD = 3'h0,
        VC_CORE = 3'h1,
        VC_DEBUG = 3'h2,
        VC_SW2 = 3'h3,
        VC_SW1 = 3'h4,
        VC_SW0 = 3'h5,
        VC_PERIPH = 3'h6
    } vec_class_e;

    typedef enum logic {
        ST_IDLE = 1'h0,
        ST_GRANT = 1'h1
    } arb_state_e;

    // What the core receives with a grant.
    typedef struct packed {
        logic [`IPV_VEC_W-1:0] vector;
        logic [`IPV_LVL_W-1:0] level;
        logic [`IPV_ADDR_W-1:0] addr;
    } grant_s;

endpackage

/* File: verification/core_model.sv */
// Model of the processor core that takes granted interrupt vectors.
// Assumes the controller's clock and active-low reset.
`timescale 1ns/1ps

module core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Grant handshake
    input wire logic irq_valid,
    input wire logic [3:0] ack_delay,
    output logic irq_ack
);
    logic [3:0] wait_count;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            wait_count <= 4'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            wait_count <= 4'h0;
        end else if (irq_valid) begin
            if (wait_count == ack_delay) begin
                irq_ack <= 1'b1;
            end else begin
                wait_count <= wait_count + 4'h1;
            end
        end
    end
endmodule

/* File: verification/interrupt_priority_vectoring_bench.sv */
// Self-checking bench of the interrupt priority and vectoring block.
// Assumes the core model acknowledges each grant after a set delay.
`timescale 1ns/1ps

module interrupt_priority_vectoring_bench;
    import ipv_pkg::*;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [50:0] req = '0;
    logic [50:0][1:0] level_cfg = '0;
    logic ext_request_a = 1'b0;
    logic ext_request_b = 1'b0;
    logic [20:0] vector_base_register = 21'h1f_ffd0;
    logic [3:0] ack_delay = 4'h0;
    logic irq_ack;
    logic irq_valid;
    grant_s grant;
    int fail_count = 0;
    int check_count = 0;
    localparam logic [50:0] RSVD = 51'h0_1030_020e_3103;

    always #5 mclk = ~mclk;

    interrupt_priority_vectoring u_dut (.mclk(mclk), .rst_b(rst_b), .req(req),
        .level_cfg(level_cfg), .ext_request_a(ext_request_a), .ext_request_b(ext_request_b),
        .vector_base_register(vector_base_register), .irq_ack(irq_ack),
        .irq_valid(irq_valid), .grant(grant));

    core_model u_core (.mclk(mclk), .rst_b(rst_b), .irq_valid(irq_valid),
        .ack_delay(ack_delay), .irq_ack(irq_ack));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [1:0] exp_lvl(input int v, input logic [1:0] c);
        if (v >= 2 && v <= 5) return 2'h3;
        if (v >= 6 && v <= 11) return (c == 2'h0) ? 2'h1 : c;
        if (v >= 14 && v <= 16) return 2'(16 - v);
        return (c == 2'h3) ? 2'h2 : c;
    endfunction

    // Waits for a grant, checks it, drops its source and follows it to the acknowledge.
    task automatic serve(input int v, input logic [1:0] lvl);
        int n;
        grant_s held;
        n = 0;
        while (irq_valid !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("vector", 32'(grant.vector), 32'(v));
        check("level", 32'(grant.level), 32'(lvl));
        check("addr", 32'(grant.addr), 32'(21'(vector_base_register + 21'(2 * v))));
        held = grant;
        if (v == 17) ext_request_a = 1'b0;
        else if (v == 18) ext_request_b = 1'b0;
        else req[v] = 1'b0;
        while (irq_ack !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
            check("hold", 32'({irq_valid, grant}), 32'({1'b1, held}));
        end
        @(negedge mclk);
        check("gap", 32'(irq_valid), 32'h0);
    endtask

    task automatic t_reset();
        check("reset", 32'({irq_valid, grant}), 32'h0);
    endtask

    // Resets in the middle of a held grant; the grant must clear and stay clear.
    task automatic t_mid_reset();
        int n;
        n = 0;
        ack_delay = 4'h8;
        req[20] = 1'b1;
        while (irq_valid !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check("pre reset", 32'(irq_valid), 32'h1);
        rst_b = 1'b0;
        req[20] = 1'b0;
        @(negedge mclk);
        check("in reset", 32'({irq_valid, grant}), 32'h0);
        rst_b = 1'b1;
        @(negedge mclk);
        check("after reset", 32'({irq_valid, grant}), 32'h0);
        @(negedge mclk);
        check("idle after reset", 32'(irq_valid), 32'h0);
    endtask

    task automatic t_single();
        for (int v = 2; v <= 50; v++) begin
            if (RSVD[v] == 1'b0) begin
                level_cfg[v] = 2'(v);
                req[v] = 1'b1;
                serve(v, exp_lvl(v, 2'(v)));
            end
        end
    endtask

    task automatic t_reserved();
        level_cfg = '1;
        req = RSVD;
        repeat (10) begin
            @(negedge mclk);
            check("reserved", 32'(irq_valid), 32'h0);
        end
        req = '0;
    endtask

    task automatic t_priority();
        int order[9] = '{3, 14, 31, 40, 6, 15, 50, 16, 30};
        logic [1:0] lvl[9] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};
        ack_delay = 4'h6;
        vector_base_register = 21'h00_0200;
        level_cfg = '0;
        level_cfg[31] = 2'h2;
        level_cfg[40] = 2'h3;
        level_cfg[50] = 2'h1;
        level_cfg[16] = 2'h3;
        level_cfg[15] = 2'h3;
        foreach (order[i]) req[order[i]] = 1'b1;
        foreach (order[i]) serve(order[i], lvl[i]);
    endtask

    task automatic t_pins();
        ack_delay = 4'h2;
        level_cfg[17] = 2'h1;
        level_cfg[18] = 2'h3;
        ext_request_a = 1'b1;
        ext_request_b = 1'b1;
        serve(18, 2'h2);
        serve(17, 2'h1);
    endtask

    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        t_reset();
        t_single();
        t_reserved();
        t_priority();
        t_pins();
        t_mid_reset();
        report_and_stop();
    end
endmodule
